// File: hdl/etx_cfg.svh
`ifndef ETX_CFG_SVH
`define ETX_CFG_SVH
// ====================================
// register byte offsets; signaling block given by its upper address nibble
`define ETX_A_CTRL  8'h00
`define ETX_A_TS1   8'h04
`define ETX_A_TSSEL 8'h08
`define ETX_A_CMD   8'h0C
`define ETX_A_FIFO  8'h10
`define ETX_A_STAT  8'h14
`define ETX_A_SAMF0 8'h18
`define ETX_A_SAMF1 8'h1C
`define ETX_A_CAS   4'h2
// ====================================
// control register fields
`define ETX_C_HMODE 1:0
`define ETX_C_AFX   2
`define ETX_C_BSEL  3
`define ETX_C_CMODE 5:4
`define ETX_C_INV1  6
`define ETX_C_INV2  7
`define ETX_C_INV3  8
`define ETX_C_SASRC 10:9
`define ETX_C_SASEL 15:11
`define ETX_C_SAW   20:16
`define ETX_C_EN2   21
`define ETX_C_EN3   22
// ====================================
// slot select fields and command bits
`define ETX_T_CH2   4:0
`define ETX_T_CH3   12:8
`define ETX_T_IDLE  23:16
`define ETX_K_REP   0
`define ETX_K_XMIT  1
`define ETX_K_XRES  2
`define ETX_K_SRES  3
// ====================================
// reset values and framing constants
`define ETX_FLAG      8'h7E
`define ETX_TSSEL_RST {`ETX_FLAG, 16'h0000}
`define ETX_DEPTH     7'h40
`define ETX_CRC_INIT  16'hFFFF
`define ETX_CRC_POLY  16'h8408
`define ETX_TS16      5'h10
`define ETX_LAST_FR   4'hF
`define ETX_LAST_POS  8'hFF
`define ETX_STUFF_RUN 3'h5
`endif

// File: hdl/etx_pkg.sv
`default_nettype none
package etx_pkg;
  typedef enum logic [1:0] {HM_HDLC, HM_TRANSP, HM_SS7} etx_hmode_t;
  typedef enum logic [1:0] {CM_NONE, CM_SERIAL, CM_UP} etx_cmode_t;
  typedef enum logic [1:0] {SA_WORD, SA_MFRAME, SA_HDLC} etx_sasrc_t;
  typedef enum logic [2:0] {ES_IDLE, ES_OPEN, ES_DATA, ES_CRC, ES_CLOSE} etx_est_t;
  // ====================================
  // link pins as sampled together
  typedef struct packed {
    logic sig;
    logic data;
    logic sync;
    logic clk;
  } etx_link_t;
  // ====================================
  // state of the controller, all but the queue memory
  typedef struct packed {
    etx_link_t        m;
    etx_link_t        sy;
    logic             clk_d;
    logic [7:0]       pos;
    logic [3:0]       fr;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [31:0]      ctrl;
    logic [31:0]      ts1;
    logic [23:0]      tssel;
    logic             rep;
    logic [39:0]      samf;
    logic [127:0]     cas;
    logic [6:0]       cnt;
    logic [6:0]       flen;
    logic             pend;
    logic             upd;
    etx_est_t         st;
    logic [15:0]      sh;
    logic [15:0]      crc;
    logic [4:0]       nb;
    logic [2:0]       ones;
    logic [6:0]       rd;
    logic             fisu;
    logic [7:0]       lbsn;
    logic [7:0]       lfsn;
    logic [31:0][3:0] cap;
    logic [31:0][3:0] nib;
    logic [7:0]       cap16;
    logic [7:0]       mf16;
    logic             line;
    logic             sysb;
    logic             strobe;
  } etx_state_t;
endpackage
`default_nettype wire

// File: hdl/etx_tx_sig_ctrl.sv
// Contract
// - hdlc mode: flags, frame check sequence, zero insertion, idle code between frames
// - outgoing data queued in a 64 byte transmit queue
// - signaling bits merged into data from system data or signaling input
// - transparent mode sends queue bytes raw, no flags, check or stuffing
// - optionally the queue contents are sent over and over
// - channel one uses any set of time slots 1 to 31, transmit set own register
// - channels two and three each use one programmable time slot
// - each channel goes toward line side or, inverse, toward system side
// - ss7 only on channel one, active once mode selects it, sends automatically
// - ss7 units open with flag, are zero stuffed, carry crc16
// - a queued unit is sent once or repeatedly, each complete with framing
// - with fill enabled and nothing queued, fill units carry last sequence numbers
// - automatic sending pauses while the queue is updated, then resumes
// - repeat bit resends continuously until host clears it or resets
// - spare bits come from word register, multiframe registers or channel one
// - per-bit select over spare bits 4 to 8 picks which are overwritten
// - serial signaling input sampled on system clock, aligned by sync pulse
// - ordinary slots and slot 0 latch bits 5 to 8 only; slot 16 in full
// - signaling multiframe inserted frame aligned; input valid in last frame
// - serial signaling read only in last frame of each multiframe
// - processor-written signaling replaces external serial signaling
// - with no signaling mode, system data passes unchanged
// - processor mode sends sixteen signaling bytes in slot 16 from multiframe start
`include "etx_cfg.svh"
`default_nettype none
module etx_tx_sig_ctrl
  import etx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        tx_system_clock,
  input  wire logic        tx_frame_sync_pulse,
  input  wire logic        tx_system_data_in,
  input  wire logic        tx_signaling_in,
  output logic             tx_line_data,
  output logic             tx_line_strobe,
  output logic             tx_sys_data
);
  etx_state_t  s;
  etx_state_t  n;
  logic [7:0]  fifo_mem [64];
  etx_hmode_t  hm;
  etx_cmode_t  cm;
  etx_sasrc_t  sasrc;
  logic        transp;
  logic        step;
  logic        run;
  logic [7:0]  cpos;
  logic [3:0]  cfr;
  logic [4:0]  ts;
  logic [2:0]  bi;
  logic [2:0]  sai;
  logic        sa_hit;
  logic        ch1;
  logic        ch2;
  logic        ch3;
  logic        lb;
  logic        sb;
  logic        hb;
  logic        up_bit;
  logic        bend;
  logic [6:0]  nxt;
  logic [7:0]  nbyte;
  logic [6:0]  len;
  logic        acc;
  logic        wr;
  logic        fifo_we;
  logic        hit;
  logic [31:0] rdat;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? `ETX_CRC_POLY : 16'h0000);
  endfunction

  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign prdata         = s.prdata;
  assign tx_line_data   = s.line;
  assign tx_line_strobe = s.strobe;
  assign tx_sys_data    = s.sysb;

  // ====================================
  // read decode
  always_comb
  begin
    hit  = 1'b1;
    rdat = 32'h0000_0000;
    case (paddr)
      `ETX_A_CTRL:  rdat = s.ctrl;
      `ETX_A_TS1:   rdat = s.ts1;
      `ETX_A_TSSEL: rdat = {8'h00, s.tssel};
      `ETX_A_CMD:   rdat = {31'h0, s.rep};
      `ETX_A_FIFO:  rdat = 32'h0000_0000;
      `ETX_A_STAT:  rdat = {22'h0, (s.st != ES_IDLE), s.upd, s.pend, s.cnt};
      `ETX_A_SAMF0: rdat = s.samf[31:0];
      `ETX_A_SAMF1: rdat = {24'h0, s.samf[39:32]};
      default:
      begin
        hit  = (paddr[7:4] == `ETX_A_CAS) && (paddr[1:0] == 2'b00);
        rdat = hit ? s.cas[paddr[3:2]*32 +: 32] : 32'h0000_0000;
      end
    endcase
  end

  // ====================================
  // next state
  always_comb
  begin
    n      = s;
    hm     = etx_hmode_t'(s.ctrl[`ETX_C_HMODE]);
    cm     = etx_cmode_t'(s.ctrl[`ETX_C_CMODE]);
    sasrc  = etx_sasrc_t'(s.ctrl[`ETX_C_SASRC]);
    transp = (hm == HM_TRANSP);
    // link pins pass two flops; edges are found on the second
    n.m    = {tx_signaling_in, tx_system_data_in, tx_frame_sync_pulse, tx_system_clock};
    n.sy   = s.m;
    n.clk_d = s.sy.clk;
    n.strobe = 1'b0;
    step   = s.sy.clk & ~s.clk_d;
    cpos   = s.sy.sync ? 8'h00 : s.pos;
    cfr    = s.sy.sync ? 4'h0 : s.fr;
    ts     = cpos[7:3];
    bi     = cpos[2:0];
    sai    = bi - 3'h3;
    sa_hit = (ts == 5'h00) && cfr[0] && (bi >= 3'h3) && s.ctrl[11 + sai];
    ch1    = (s.ts1[ts] && (ts != 5'h00)) || (sa_hit && (sasrc == SA_HDLC));
    ch2    = s.ctrl[`ETX_C_EN2] && (ts == s.tssel[`ETX_T_CH2]);
    ch3    = s.ctrl[`ETX_C_EN3] && (ts == s.tssel[`ETX_T_CH3]);
    run    = step && ch1;
    up_bit = s.cas[{cfr, ~bi}];
    hb     = 1'b1;
    bend   = 1'b0;
    nxt    = s.rd + 7'h01;
    nbyte  = s.fisu ? ((nxt == 7'h01) ? s.lfsn : 8'h00) : fifo_mem[nxt[5:0]];
    len    = s.fisu ? 7'h03 : s.flen;

    // ==================================
    // channel one frame engine, advances only in its own slots
    if (run)
    begin
      case (s.st)
        ES_IDLE:
        begin
          hb   = s.tssel[16 + s.nb[2:0]];
          n.nb = s.nb + 5'h01;
          bend = (s.nb[2:0] == 3'h7);
        end
        ES_OPEN, ES_CLOSE:
        begin
          hb   = s.sh[0];
          n.sh = s.sh >> 1;
          n.nb = s.nb + 5'h01;
          if (s.nb == 5'h07)
          begin
            if (s.st == ES_OPEN)
            begin
              n.st   = ES_DATA;
              n.rd   = 7'h00;
              n.nb   = 5'h00;
              n.ones = 3'h0;
              n.crc  = `ETX_CRC_INIT;
              n.sh   = {8'h00, s.fisu ? s.lbsn : fifo_mem[0]};
            end
            else
            begin
              bend = 1'b1;
              if (!s.fisu && !s.rep)
              begin
                n.pend = 1'b0;
                n.cnt  = 7'h00;
              end
              if (!s.fisu && (hm == HM_SS7))
              begin
                n.lbsn = fifo_mem[0];
                n.lfsn = fifo_mem[1];
              end
            end
          end
        end
        ES_DATA, ES_CRC:
        begin
          if (!transp && (s.ones == `ETX_STUFF_RUN))
          begin
            hb     = 1'b0;
            n.ones = 3'h0;
          end
          else
          begin
            hb     = s.sh[0];
            n.sh   = s.sh >> 1;
            n.nb   = s.nb + 5'h01;
            n.ones = hb ? s.ones + 3'h1 : 3'h0;
            if (s.st == ES_DATA)
            begin
              n.crc = crc_step(s.crc, hb);
              if (s.nb == 5'h07)
              begin
                n.nb = 5'h00;
                if (nxt < len)
                begin
                  n.rd = nxt;
                  n.sh = {8'h00, nbyte};
                end
                else if (transp)
                begin
                  // raw mode loops on itself, no framing in between
                  if (s.rep)
                  begin
                    n.rd = 7'h00;
                    n.sh = {8'h00, fifo_mem[0]};
                  end
                  else
                  begin
                    n.pend = 1'b0;
                    n.cnt  = 7'h00;
                    n.st   = ES_IDLE;
                  end
                end
                else
                begin
                  n.st = ES_CRC;
                  n.sh = ~crc_step(s.crc, hb);
                end
              end
            end
            else if (s.nb == 5'h0F)
            begin
              n.st = ES_CLOSE;
              n.nb = 5'h00;
              n.sh = {8'h00, `ETX_FLAG};
            end
          end
        end
        default: n.st = ES_IDLE;
      endcase
    end

    // ==================================
    // start of next frame at a byte boundary
    if (bend)
    begin
      n.nb   = 5'h00;
      n.ones = 3'h0;
      if (n.pend && !n.upd && transp)
      begin
        n.st   = ES_DATA;
        n.rd   = 7'h00;
        n.fisu = 1'b0;
        n.sh   = {8'h00, fifo_mem[0]};
      end
      else if (!transp && !n.upd && (n.pend || (hm == HM_SS7 && s.ctrl[`ETX_C_AFX])))
      begin
        n.st   = ES_OPEN;
        n.fisu = ~n.pend;
        n.sh   = {8'h00, `ETX_FLAG};
      end
      else
        n.st = ES_IDLE;
    end

    // ==================================
    // serial signaling capture, last frame only
    if (step && (cm == CM_SERIAL) && (cfr == `ETX_LAST_FR))
    begin
      if (ts == `ETX_TS16)
        n.cap16[~bi] = s.sy.sig;
      else if (bi[2])
        n.cap[ts][~bi[1:0]] = s.sy.sig;
      // double buffer so frame 15 insertion still sees the old set
      if (cpos == `ETX_LAST_POS)
      begin
        n.nib  = n.cap;
        n.mf16 = n.cap16;
      end
    end

    // ==================================
    // outgoing bit composition
    lb = s.ctrl[`ETX_C_BSEL] ? s.sy.sig : s.sy.data;
    if ((ts == `ETX_TS16) && (cm == CM_UP))
      lb = up_bit;
    else if ((ts == `ETX_TS16) && (cm == CM_SERIAL))
      lb = (cfr == 4'h0) ? s.mf16[~bi] : s.nib[{bi[2], cfr}][~bi[1:0]];
    if (sa_hit && (sasrc == SA_WORD))
      lb = s.ctrl[16 + sai];
    else if (sa_hit && (sasrc == SA_MFRAME))
      lb = s.samf[{sai, cfr[3:1]}];
    sb = 1'b1;
    if (ch2 || ch3)
    begin
      if (ch2 ? s.ctrl[`ETX_C_INV2] : s.ctrl[`ETX_C_INV3])
        sb = s.tssel[16 + bi];
      else
        lb = s.tssel[16 + bi];
    end
    if (ch1)
    begin
      if (s.ctrl[`ETX_C_INV1])
        sb = hb;
      else
        lb = hb;
    end
    if (step)
    begin
      n.line   = lb;
      n.sysb   = sb;
      n.strobe = 1'b1;
      n.pos    = cpos + 8'h01;
      if (cpos == `ETX_LAST_POS)
        n.fr = cfr + 4'h1;
    end

    // ==================================
    // bus slave: one wait state, answer registered
    acc     = psel && penable && s.pready;
    wr      = acc && pwrite;
    fifo_we = wr && (paddr == `ETX_A_FIFO) && (s.cnt < `ETX_DEPTH);
    n.pready = psel && penable && !s.pready;
    if (psel && !s.pready)
    begin
      n.prdata  = rdat;
      n.pslverr = !hit;
    end
    if (fifo_we)
    begin
      n.cnt = s.cnt + 7'h01;
      n.upd = 1'b1;
    end
    if (wr)
    begin
      case (paddr)
        `ETX_A_CTRL:  n.ctrl = {9'h000, pwdata[22:0]};
        `ETX_A_TS1:   n.ts1 = pwdata;
        `ETX_A_TSSEL: n.tssel = {pwdata[23:16], 3'h0, pwdata[12:8], 3'h0, pwdata[4:0]};
        `ETX_A_SAMF0: n.samf[31:0] = pwdata;
        `ETX_A_SAMF1: n.samf[39:32] = pwdata[7:0];
        `ETX_A_CMD:
        begin
          n.rep = pwdata[`ETX_K_REP];
          if (pwdata[`ETX_K_XMIT] && (s.cnt != 7'h00))
          begin
            n.pend = 1'b1;
            n.flen = s.cnt;
            n.upd  = 1'b0;
          end
          if (pwdata[`ETX_K_XRES] || pwdata[`ETX_K_SRES])
          begin
            n.rep  = 1'b0;
            n.pend = 1'b0;
            n.upd  = 1'b0;
            n.st   = ES_IDLE;
            n.nb   = 5'h00;
            if (pwdata[`ETX_K_XRES])
              n.cnt = 7'h00;
          end
        end
        default:
        begin
          if (hit && (paddr != `ETX_A_FIFO) && (paddr != `ETX_A_STAT))
            n.cas[paddr[3:2]*32 +: 32] = pwdata;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s       <= '0;
      s.tssel <= `ETX_TSSEL_RST;
      s.st    <= ES_IDLE;
      s.line  <= 1'b1;
      s.sysb  <= 1'b1;
    end
    else
      s <= n;
  end

  always_ff @(posedge core_clk)
  begin
    if (fifo_we)
      fifo_mem[s.cnt[5:0]] <= pwdata[7:0];
  end

  // ====================================
  // checks
  fifo_bound_a: assert property (s.cnt <= `ETX_DEPTH) else $error("queue count above depth");
  stuff_run_a: assert property ((s.st == ES_DATA && !transp) |-> s.ones <= `ETX_STUFF_RUN)
    else $error("ones run exceeds stuffing limit");
  flag_open_a: assert property ((s.st == ES_OPEN && s.nb == 5'h00) |-> s.sh[7:0] == `ETX_FLAG)
    else $error("unit does not open with a flag");
  transp_raw_a: assert property ((run && s.st == ES_DATA && transp && !s.ctrl[`ETX_C_INV1])
    |=> tx_line_data == $past(s.sh[0])) else $error("raw mode altered a data bit");
  cas_up_a: assert property ((step && ts == `ETX_TS16 && cm == CM_UP && !ch1 && !ch2 && !ch3)
    |=> tx_line_data == $past(up_bit)) else $error("signaling register bit not sent");
  pass_thru_a: assert property ((step && cm == CM_NONE && !ch1 && !ch2 && !ch3 && !sa_hit
    && !s.ctrl[`ETX_C_BSEL]) |=> tx_line_data == $past(s.sy.data)) else $error("system data altered");
  serial_last_a: assert property (!$stable(s.cap) |-> $past(cfr) == `ETX_LAST_FR)
    else $error("serial signaling taken outside last frame");
  strobe_gap_a: assert property (tx_line_strobe |=> !tx_line_strobe [*3])
    else $error("bit strobes too close");
  repeat_loop_a: assert property ((run && s.st == ES_CLOSE && s.nb == 5'h07 && s.rep && s.pend
    && !s.upd && !wr) |=> s.st == ES_OPEN) else $error("repeat did not restart the unit");
  pause_upd_a: assert property ((s.upd && s.st == ES_IDLE && !wr) |=> s.st == ES_IDLE)
    else $error("sending started during queue update");
  apb_ready_a: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer not in one wait state");
endmodule
`default_nettype wire

// File: bench/etx_link_model.sv
`default_nettype none
module etx_link_model (
  input  wire logic   run,
  output logic        tx_system_clock,
  output logic        tx_frame_sync_pulse,
  output logic        tx_system_data_in,
  output logic        tx_signaling_in,
  output logic [12:0] bit_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================================
  // highway pins
  // sync marks bit 1 of slot 0 of frame 0
  assign tx_frame_sync_pulse = (bit_cnt[11:0] == 12'h000);
  assign tx_system_data_in = bit_cnt[0] ^ bit_cnt[2] ^ bit_cnt[5] ^ bit_cnt[9];
  // last frame differs, so a capture taken in any other frame shows up
  assign tx_signaling_in = bit_cnt[1] ^ bit_cnt[3] ^ bit_cnt[6] ^ (bit_cnt[11:8] == 4'hF);
  // ====================================
  // free-running highway clock
  // one process owns clock and counter, so each has a single driver
  // pins move only after the falling edge, so they hold across each sampling edge
  initial
  begin
    tx_system_clock = 1'b0;
    bit_cnt = 13'h0000;
    forever
    begin
      wait (run);
      #24 tx_system_clock = 1'b1;
      #24 tx_system_clock = 1'b0;
      bit_cnt = bit_cnt + 13'h0001;
    end
  end
endmodule
`default_nettype wire

// File: bench/etx_tx_sig_ctrl_tb.sv
`include "etx_cfg.svh"
`default_nettype none
module etx_tx_sig_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] idle_code = 8'hA5;
  logic        core_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        run;
  logic        lclk;
  logic        lsync;
  logic        ldata;
  logic        lsig;
  logic [12:0] bit_cnt;
  logic        line_data;
  logic        line_strobe;
  logic        sys_data;
  logic [12:0] lat_cnt;
  logic        lat_d;
  logic        lat_s;
  logic [7:0]  cap;
  logic [31:0] cas_w [4];
  logic        done;
  logic        mf;
  logic [3:0]  fr;
  logic [4:0]  sl;
  logic [2:0]  b;
  logic        e;
  logic        sk;
  int          errors;
  int          tests_run;

  etx_tx_sig_ctrl DUT (
    .core_clk            (core_clk),
    .srst                (srst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .prdata              (prdata),
    .tx_system_clock     (lclk),
    .tx_frame_sync_pulse (lsync),
    .tx_system_data_in   (ldata),
    .tx_signaling_in     (lsig),
    .tx_line_data        (line_data),
    .tx_line_strobe      (line_strobe),
    .tx_sys_data         (sys_data)
  );

  etx_link_model link (
    .run                 (run),
    .tx_system_clock     (lclk),
    .tx_frame_sync_pulse (lsync),
    .tx_system_data_in   (ldata),
    .tx_signaling_in     (lsig),
    .bit_cnt             (bit_cnt)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ====================================
  // checking and bus tasks
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hung();
    errors++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
      hung();
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic expe);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    chk(r & m, exp);
    chk({31'h0, x}, {31'h0, expe});
  endtask

  task automatic wait_cnt(input logic [12:0] t);
    int n;
    for (n = 0; n < 50000; n++)
    begin
      @(posedge core_clk);
      if (bit_cnt >= t)
        break;
    end
    if (n == 50000)
      hung();
  endtask

  // ====================================
  // line monitor
  always @(posedge lclk)
  begin
    lat_cnt = bit_cnt;
    lat_d = ldata;
    lat_s = lsig;
  end

  // slot 16 is skipped around mode changes, where its source is in flux
  always @(posedge core_clk)
  begin
    if (run === 1'b1 && line_strobe === 1'b1 && !done)
    begin
      mf = lat_cnt[12];
      fr = lat_cnt[11:8];
      sl = lat_cnt[7:3];
      b = lat_cnt[2:0];
      if (!mf && fr == 4'hF && sl == `ETX_TS16)
        cap[b] = lat_s;
      sk = mf && fr == 4'h1;
      e = (mf && fr >= 4'h2) ? lat_s : lat_d;
      if (sl == `ETX_TS16)
      begin
        sk = (mf || fr >= 4'hE) && !(mf && fr == 4'h0);
        e = mf ? cap[b] : cas_w[fr[3:2]][{fr[1:0], ~b}];
      end
      if (sl == 5'h03)
      begin
        sk = 1'b0;
        e = idle_code[b];
      end
      if (!sk)
        chk({31'h0, line_data}, {31'h0, e});
      chk({31'h0, sys_data}, 32'h1);
    end
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    hung();
  end

  // ====================================
  // main sequence
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    done = 1'b0;
    cap = 8'h00;
    errors = 0;
    tests_run = 0;
    for (int i = 0; i < 4; i++)
      cas_w[i] = 32'hC3965AE1 + 32'h11111111 * i;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdc(`ETX_A_CTRL, '1, 32'h0, 1'b0);
    rdc(`ETX_A_TS1, '1, 32'h0, 1'b0);
    rdc(`ETX_A_TSSEL, '1, {8'h00, `ETX_TSSEL_RST}, 1'b0);
    rdc(`ETX_A_STAT, '1, 32'h0, 1'b0);
    rdc(8'h40, '1, 32'h0, 1'b1);
    // one byte past the top must be dropped
    for (int i = 0; i < 65; i++)
      wr(`ETX_A_FIFO, 32'h3C + i);
    rdc(`ETX_A_STAT, 32'h7F, {25'h0, `ETX_DEPTH}, 1'b0);
    wr(`ETX_A_CMD, 32'h1);
    rdc(`ETX_A_CMD, 32'h1, 32'h1, 1'b0);
    wr(`ETX_A_CMD, 32'h4);
    rdc(`ETX_A_CMD, 32'h1, 32'h0, 1'b0);
    rdc(`ETX_A_STAT, 32'h7F, 32'h0, 1'b0);
    wr(`ETX_A_TS1, 32'h8);
    wr(`ETX_A_TSSEL, {8'h00, idle_code, 16'h0});
    for (int i = 0; i < 4; i++)
      wr({`ETX_A_CAS, 2'(i), 2'b00}, cas_w[i]);
    wr(`ETX_A_CTRL, 32'h20);
    run <= 1'b1;
    wait_cnt(13'h0E00);
    wr(`ETX_A_CTRL, 32'h10);
    wait_cnt(13'h1100);
    wr(`ETX_A_CTRL, 32'h8);
    wait_cnt(13'h1300);
    done = 1'b1;
    report_and_stop();
  end
endmodule
`default_nettype wire
